// ===== include/sbs_pkg.sv
// Constants, types and helpers for the sync burst SRAM control block
package sbs_pkg;
    // ------------------------------------------------------------------
    // Data and address geometry
    // ------------------------------------------------------------------
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;
    localparam int LOW_W = 2;
    localparam int HIGH_W = 20;
    localparam int ADDR_W = HIGH_W + LOW_W;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int PADDR_W = 8;
    localparam logic [PADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [PADDR_W-1:0] REG_STATUS = 8'h04;
    localparam int CTRL_W = 5;
    localparam int CTRL_LBO = 0;
    localparam int CTRL_FT = 1;
    localparam int CTRL_SCD = 2;
    localparam int CTRL_ZZ = 3;
    localparam int CTRL_ZQ = 4;
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h17;
    localparam int ST_ADDR_LO = 0;
    localparam int ST_BEAT_LO = 2;
    localparam int ST_SLEEP = 4;
    localparam int ST_OE = 5;
    localparam int ST_RDPEND = 6;
    localparam logic [LOW_W-1:0] BEAT_ONE = 2'h1;
    localparam logic [LOW_W-1:0] BEAT_ZERO = 2'h0;

    // ------------------------------------------------------------------
    // Cycle kinds
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CYC_DESEL,
        CYC_BEGIN_P,
        CYC_BEGIN_C,
        CYC_CONT,
        CYC_SUSP
    } sbs_cycle_t;

    // Low address bits for a given beat of a burst
    function automatic logic [LOW_W-1:0] burst_addr(
        input logic [LOW_W-1:0] base,
        input logic [LOW_W-1:0] beat,
        input logic linear_n
    );
        burst_addr = linear_n ? (base ^ beat) : LOW_W'(base + beat);
    endfunction
endpackage

// ===== rtl/sbs_ctrl.sv
// Sync burst SRAM cycle decode, burst counter, write decode and APB regs
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/10ps

// Overview of operation
// - Load low address bits as counter start
// - Linear adds beat, interleaved XORs beat
// - Counter wraps to start on fifth clock
// - Flow-through bypasses output register, else pipelined
// - Sleep request puts device in standby
// - Deselect select low gives dual cycle deselect when pipelined
// - Unconnected mode inputs take documented defaults
// - Global write low writes all bytes
// - Byte write writes only enabled lanes
// - Each lane enable controls its own lane
// - Both write inputs high means read
// - Data pins stay high impedance during writes
// - Four lanes only in wide configuration
// - Deselect uses no address, floats data
// - Processor strobe starts read at external address
// - Controller strobe starts read or write burst
// - Advance low continues burst at next address
// - Advance high suspends burst, repeats address
// - Write decode true for any write row
// - Output enable gates drivers asynchronously
// - Dummy read still advances burst counter
module sbs_ctrl
    import sbs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic chip_enable_n,
    input wire logic addr_strobe_proc_n,
    input wire logic addr_strobe_ctrl_n,
    input wire logic burst_advance_n,
    input wire logic global_write_n,
    input wire logic byte_write_n,
    input wire logic [LANES-1:0] lane_write_enables_n,
    input wire logic [HIGH_W-1:0] addr_high,
    input wire logic [LOW_W-1:0] addr_low_bits,
    input wire logic output_enable_n,
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic [DATA_W-1:0] dq_oe,
    output logic arr_en,
    output logic [ADDR_W-1:0] arr_addr,
    output logic [LANES-1:0] arr_lane_we,
    output logic [DATA_W-1:0] arr_wdata,
    input wire logic [DATA_W-1:0] arr_rdata,
    output logic drive_strength_sel
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_ff;
    logic pready_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic [LOW_W-1:0] base_ff;
    logic [LOW_W-1:0] beat_ff;
    logic [HIGH_W-1:0] upper_ff;
    logic arr_en_ff;
    logic [ADDR_W-1:0] arr_addr_ff;
    logic [LANES-1:0] arr_lane_we_ff;
    logic [DATA_W-1:0] arr_wdata_ff;
    logic rd1_ff;
    logic rd2_ff;
    logic desel1_ff;
    logic desel2_ff;
    logic [DATA_W-1:0] pipe_data_ff;
    logic [DATA_W-1:0] dq_out_ff;
    logic oe_ff;
    sbs_cycle_t cyc;
    logic act;
    logic wr_dec;
    logic [LANES-1:0] lane_mask;
    logic is_write;
    logic is_read;
    logic begin_c;
    logic cont_c;
    logic susp_c;
    logic desel_c;
    logic burst_c;
    logic [LOW_W-1:0] cur_lo;
    logic [LOW_W-1:0] nxt_lo;
    logic apb_setup_done;
    logic ctrl_wr;
    logic linear_n;
    logic ft_n;
    logic deselect_mode_sel;
    logic sleep;

    // Register map decode
    function automatic logic reg_mapped(input logic [PADDR_W-1:0] a);
        reg_mapped = (a == REG_CTRL) || (a == REG_STATUS);
    endfunction

    assign linear_n = ctrl_ff[CTRL_LBO];
    assign ft_n = ctrl_ff[CTRL_FT];
    assign deselect_mode_sel = ctrl_ff[CTRL_SCD];
    assign sleep = ctrl_ff[CTRL_ZZ];

    // ------------------------------------------------------------------
    // Cycle decode
    // ------------------------------------------------------------------
    always_comb
    begin
        if (!addr_strobe_ctrl_n && chip_enable_n)
            cyc = CYC_DESEL;
        else if (!chip_enable_n && !addr_strobe_proc_n)
            cyc = CYC_BEGIN_P;
        else if (!chip_enable_n && !addr_strobe_ctrl_n)
            cyc = CYC_BEGIN_C;
        else if (!burst_advance_n)
            cyc = CYC_CONT;
        else
            cyc = CYC_SUSP;
    end

    assign act = !sleep;
    assign wr_dec = !global_write_n || !byte_write_n;
    assign begin_c = act && (cyc == CYC_BEGIN_P || cyc == CYC_BEGIN_C);
    assign cont_c = act && (cyc == CYC_CONT);
    assign susp_c = act && (cyc == CYC_SUSP);
    assign desel_c = act && (cyc == CYC_DESEL);
    assign burst_c = act && (cyc != CYC_DESEL) && (cyc != CYC_BEGIN_P);
    assign is_write = burst_c && wr_dec;
    assign is_read = (act && cyc == CYC_BEGIN_P) || (burst_c && !wr_dec);

    // Per-lane write enables, four lanes in the wide layout
    genvar gi;
    generate
        for (gi = 0; gi < LANES; gi++)
        begin : g_lane
            assign lane_mask[gi] = !global_write_n ||
                (!byte_write_n && !lane_write_enables_n[gi]);
        end
    endgenerate

    assign cur_lo = burst_addr(base_ff, beat_ff, linear_n);
    assign nxt_lo = burst_addr(base_ff, LOW_W'(beat_ff + BEAT_ONE),
        linear_n);

    // ------------------------------------------------------------------
    // Burst counter
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            base_ff <= BEAT_ZERO;
            beat_ff <= BEAT_ZERO;
            upper_ff <= '0;
        end
        else if (act)
        begin
            unique case (cyc)
                CYC_BEGIN_P, CYC_BEGIN_C:
                begin
                    base_ff <= addr_low_bits;
                    beat_ff <= BEAT_ZERO;
                    upper_ff <= addr_high;
                end
                CYC_CONT:
                    beat_ff <= LOW_W'(beat_ff + BEAT_ONE);
                CYC_DESEL, CYC_SUSP:
                    beat_ff <= beat_ff;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Array access, sampled on the rising edge
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            arr_en_ff <= 1'b0;
            arr_addr_ff <= '0;
            arr_lane_we_ff <= '0;
            arr_wdata_ff <= '0;
        end
        else
        begin
            arr_en_ff <= is_read || is_write;
            if (begin_c)
                arr_addr_ff <= {addr_high, addr_low_bits};
            else if (cont_c)
                arr_addr_ff <= {upper_ff, nxt_lo};
            else if (susp_c)
                arr_addr_ff <= {upper_ff, cur_lo};
            arr_lane_we_ff <= is_write ? lane_mask : '0;
            arr_wdata_ff <= dq_in;
        end
    end

    // ------------------------------------------------------------------
    // Read pipeline
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd1_ff <= 1'b0;
            rd2_ff <= 1'b0;
            desel1_ff <= 1'b0;
            desel2_ff <= 1'b0;
            pipe_data_ff <= '0;
            dq_out_ff <= '0;
        end
        else
        begin
            rd1_ff <= is_read;
            rd2_ff <= rd1_ff;
            desel1_ff <= desel_c;
            desel2_ff <= desel1_ff;
            pipe_data_ff <= arr_rdata;
            dq_out_ff <= ft_n ? pipe_data_ff : arr_rdata;
        end
    end

    // Output drive enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            oe_ff <= 1'b0;
        else if (sleep || is_write)
            oe_ff <= 1'b0;
        else if (!ft_n)
        begin
            if (rd1_ff)
                oe_ff <= 1'b1;
            else if (desel1_ff)
                oe_ff <= 1'b0;
        end
        else if (rd2_ff)
            oe_ff <= 1'b1;
        else if (deselect_mode_sel ? desel1_ff : desel2_ff)
            oe_ff <= 1'b0;
    end

    // ------------------------------------------------------------------
    // APB slave, one wait state
    // ------------------------------------------------------------------
    assign apb_setup_done = psel && penable && !pready_ff;
    assign ctrl_wr = psel && penable && pready_ff && pwrite &&
        (paddr == REG_CTRL);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            prdata_ff <= '0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pready_ff <= apb_setup_done;
            if (apb_setup_done)
            begin
                pslverr_ff <= !reg_mapped(paddr);
                prdata_ff <= '0;
                if (!pwrite && paddr == REG_CTRL)
                    prdata_ff[CTRL_W-1:0] <= ctrl_ff;
                else if (!pwrite && paddr == REG_STATUS)
                begin
                    prdata_ff[ST_ADDR_LO +: LOW_W] <= cur_lo;
                    prdata_ff[ST_BEAT_LO +: LOW_W] <= beat_ff;
                    prdata_ff[ST_SLEEP] <= sleep;
                    prdata_ff[ST_OE] <= oe_ff;
                    prdata_ff[ST_RDPEND] <= rd1_ff || rd2_ff;
                end
            end
        end
    end

    // Mode selects, reset to the unconnected defaults
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_ff <= CTRL_RST;
        else if (ctrl_wr)
            ctrl_ff <= pwdata[CTRL_W-1:0];
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign pready = pready_ff;
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff;
    assign dq_out = dq_out_ff;
    assign dq_oe = {DATA_W{oe_ff && !output_enable_n}};
    assign arr_en = arr_en_ff;
    assign arr_addr = arr_addr_ff;
    assign arr_lane_we = arr_lane_we_ff;
    assign arr_wdata = arr_wdata_ff;
    assign drive_strength_sel = ctrl_ff[CTRL_ZQ];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_begin;
        begin_c && !ctrl_wr;
    endsequence

    sequence s_cont4;
        (cont_c && !ctrl_wr)[*4];
    endsequence

    property p_load;
        @(posedge pclk) disable iff (!presetn)
        begin_c |=> base_ff == $past(addr_low_bits) && beat_ff == BEAT_ZERO;
    endproperty
    a_load: assert property (p_load)
        else $error("burst start not loaded");

    property p_order;
        @(posedge pclk) disable iff (!presetn)
        cont_c |=> arr_addr_ff[LOW_W-1:0] == ($past(linear_n) ?
            ($past(base_ff) ^ $past(beat_ff) ^ BEAT_ONE ^
            ($past(beat_ff) ^ LOW_W'($past(beat_ff) + BEAT_ONE)) ^ BEAT_ONE)
            : LOW_W'($past(base_ff) + $past(beat_ff) + BEAT_ONE));
    endproperty
    a_order: assert property (p_order)
        else $error("burst order wrong");

    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
        s_begin ##1 s_cont4 |=>
            arr_addr_ff[LOW_W-1:0] == $past(addr_low_bits, 5);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("burst did not wrap to start");

    property p_flow;
        @(posedge pclk) disable iff (!presetn)
        is_read && !ft_n ##1 !ft_n |=> dq_out_ff == $past(arr_rdata);
    endproperty
    a_flow: assert property (p_flow)
        else $error("flow-through data wrong");

    property p_pipe;
        @(posedge pclk) disable iff (!presetn)
        is_read && ft_n ##1 ft_n ##1 ft_n |=>
            dq_out_ff == $past(arr_rdata, 2);
    endproperty
    a_pipe: assert property (p_pipe)
        else $error("pipelined data wrong");

    property p_sleep;
        @(posedge pclk) disable iff (!presetn)
        sleep |=> !arr_en_ff && !oe_ff;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("access during standby");

    property p_scd;
        @(posedge pclk) disable iff (!presetn)
        desel1_ff && deselect_mode_sel && ft_n && !rd2_ff |=> !oe_ff;
    endproperty
    a_scd: assert property (p_scd)
        else $error("single deselect turn-off late");

    property p_global;
        @(posedge pclk) disable iff (!presetn)
        is_write && !global_write_n |=> &arr_lane_we_ff;
    endproperty
    a_global: assert property (p_global)
        else $error("global write missed a lane");

    property p_byte;
        @(posedge pclk) disable iff (!presetn)
        is_write && global_write_n && !byte_write_n |=>
            arr_lane_we_ff == ~$past(lane_write_enables_n);
    endproperty
    a_byte: assert property (p_byte)
        else $error("byte write lanes wrong");

    property p_read;
        @(posedge pclk) disable iff (!presetn)
        act && global_write_n && byte_write_n && cyc != CYC_DESEL |=>
            arr_en_ff && arr_lane_we_ff == '0;
    endproperty
    a_read: assert property (p_read)
        else $error("read cycle wrote");

    property p_wr_hiz;
        @(posedge pclk) disable iff (!presetn)
        is_write |=> !oe_ff;
    endproperty
    a_wr_hiz: assert property (p_wr_hiz)
        else $error("drivers on during write");

    property p_desel;
        @(posedge pclk) disable iff (!presetn)
        desel_c |=> !arr_en_ff;
    endproperty
    a_desel: assert property (p_desel)
        else $error("deselect accessed array");

    property p_addr_strobe_proc_n;
        @(posedge pclk) disable iff (!presetn)
        act && !chip_enable_n && !addr_strobe_proc_n |=> arr_en_ff &&
            arr_lane_we_ff == '0 &&
            arr_addr_ff == $past({addr_high, addr_low_bits});
    endproperty
    a_addr_strobe_proc_n: assert property (p_addr_strobe_proc_n)
        else $error("processor strobe start wrong");

    property p_susp;
        @(posedge pclk) disable iff (!presetn)
        cont_c ##1 susp_c |=> arr_addr_ff == $past(arr_addr_ff);
    endproperty
    a_susp: assert property (p_susp)
        else $error("suspend moved the address");
endmodule

// ===== verif/sbs_array_model.sv
// Behavioural storage array answering the block's array port
`timescale 1ns/10ps
module sbs_array_model
    import sbs_pkg::*;
(
    input wire logic pclk,
    input wire logic arr_en,
    input wire logic [ADDR_W-1:0] arr_addr,
    input wire logic [LANES-1:0] arr_lane_we,
    input wire logic [DATA_W-1:0] arr_wdata,
    output logic [DATA_W-1:0] arr_rdata
);
    logic [DATA_W-1:0] mem [16];

    // --------------------------------------------------------------
    // Storage
    // --------------------------------------------------------------
    initial
    begin
        for (int i = 0; i < 16; i++)
            mem[i] = {14'h2A5, ADDR_W'(i)};
    end

    // Read answers in the same cycle as the address
    assign arr_rdata = mem[arr_addr[3:0]];

    // Each lane strobe writes its own lane only
    always @(posedge pclk)
    begin
        for (int l = 0; l < LANES; l++)
            if (arr_en && arr_lane_we[l])
                mem[arr_addr[3:0]][l*LANE_W +: LANE_W] <=
                    arr_wdata[l*LANE_W +: LANE_W];
    end
endmodule

// ===== verif/sync_burst_sram_control_test.sv
// Self-checking bench for the sync burst SRAM control block
`timescale 1ns/10ps
module sync_burst_sram_control_test
    import sbs_pkg::*;
;
    typedef struct {
        bit acc;
        bit w;
        logic [ADDR_W-1:0] a;
        logic [LANES-1:0] we;
        logic [DATA_W-1:0] rd;
        logic [DATA_W-1:0] wd;
    } sbs_hist_t;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [PADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic chip_enable_n, addr_strobe_proc_n, addr_strobe_ctrl_n;
    logic burst_advance_n, global_write_n, byte_write_n;
    logic output_enable_n, arr_en, drive_strength_sel, err;
    logic [LANES-1:0] lane_write_enables_n, arr_lane_we;
    logic [HIGH_W-1:0] addr_high, hi;
    logic [LOW_W-1:0] addr_low_bits, base, beat;
    logic [DATA_W-1:0] dq_in, dq_out, dq_oe, arr_wdata, arr_rdata;
    logic [ADDR_W-1:0] arr_addr;
    logic [4:0] cfg;
    logic [DATA_W-1:0] mem [16];
    sbs_hist_t h [4];
    int mismatches, compares;

    sbs_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .chip_enable_n,
        .addr_strobe_proc_n, .addr_strobe_ctrl_n, .burst_advance_n,
        .global_write_n, .byte_write_n, .lane_write_enables_n,
        .addr_high, .addr_low_bits, .output_enable_n, .dq_in, .dq_out,
        .dq_oe, .arr_en, .arr_addr, .arr_lane_we, .arr_wdata, .arr_rdata,
        .drive_strength_sel);

    sbs_array_model arr (.pclk, .arr_en, .arr_addr, .arr_lane_we,
        .arr_wdata, .arr_rdata);

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [DATA_W-1:0] got,
                       input logic [DATA_W-1:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [PADDR_W-1:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One bus cycle; checks what earlier cycles should show now
    task automatic step(input int kind);
        logic ce, pr, ct, av, gw, bw, oe, w;
        logic [LANES-1:0] ln;
        logic [LOW_W-1:0] lo;
        logic [HIGH_W-1:0] hv;
        logic [DATA_W-1:0] dat;
        int d;
        @(posedge pclk);
        for (int j = 3; j > 0; j--)
            h[j] = h[j-1];
        ce = (kind == 0) ? 1'b1 : (kind < 3) ? 1'b0 : 1'($urandom);
        pr = (kind == 1) ? 1'b0 : (kind == 0 || ce) ? 1'($urandom) : 1'b1;
        ct = (kind == 1) ? 1'($urandom) : (kind > 2);
        av = (kind == 3) ? 1'b0 : (kind == 4) ? 1'b1 : 1'($urandom);
        gw = ($urandom_range(3) != 0);
        bw = ($urandom_range(2) != 0);
        oe = ($urandom_range(5) == 0);
        ln = LANES'($urandom);
        lo = LOW_W'($urandom);
        hv = HIGH_W'($urandom_range(3));
        w = (!gw || !bw) && kind != 1;
        h[0].acc = kind != 0 && !cfg[3];
        h[0].w = w && h[0].acc;
        if (h[0].acc && kind < 3)
        begin
            base = lo;
            beat = 2'h0;
            hi = hv;
        end
        else if (h[0].acc && kind == 3)
            beat = beat + 2'h1;
        h[0].a = {hi, cfg[0] ? base ^ beat : base + beat};
        h[0].we = !w ? 4'h0 : !gw ? 4'hF : ~ln;
        h[0].rd = mem[h[0].a[3:0]];
        dat = w ? DATA_W'({$urandom, $urandom}) : ~dq_in;
        h[0].wd = dat;
        for (int l = 0; l < LANES; l++)
            if (h[0].acc && h[0].we[l])
                mem[h[0].a[3:0]][l*LANE_W +: LANE_W] = dat[l*LANE_W +: LANE_W];
        chip_enable_n <= ce;
        addr_strobe_proc_n <= pr;
        addr_strobe_ctrl_n <= ct;
        burst_advance_n <= av;
        global_write_n <= gw;
        byte_write_n <= bw;
        lane_write_enables_n <= ln;
        addr_high <= hv;
        addr_low_bits <= lo;
        output_enable_n <= oe;
        dq_in <= dat;
        #1;
        chk(arr_en, h[1].acc);
        if (h[1].acc)
        begin
            chk(arr_addr, h[1].a);
            chk(arr_lane_we, h[1].we);
            if (h[1].w)
            begin
                chk(dq_oe, '0);
                chk(arr_wdata, h[1].wd);
            end
        end
        d = cfg[1] ? 3 : 2;
        if (h[d].acc && !h[d].w && !h[1].w && !(d == 3 && h[2].w))
        begin
            chk(dq_oe, {DATA_W{!oe}});
            if (!oe)
                chk(dq_out, h[d].rd);
        end
        // Drivers off after a deselect, by deselect mode
        if (cfg[3] || ((!cfg[1] || cfg[2]) ? !h[2].acc &&
            !(cfg[1] && h[3].acc && !h[3].w) : !h[3].acc))
            chk(dq_oe, '0);
    endtask

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial
    begin
        void'($urandom(32'hF557B22D));
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {chip_enable_n, addr_strobe_proc_n, burst_advance_n} = 3'h7;
        {global_write_n, byte_write_n, output_enable_n} = 3'h6;
        addr_strobe_ctrl_n = 1'b0;
        lane_write_enables_n = 4'hF;
        {addr_high, addr_low_bits, hi, base, beat, cfg} = '0;
        dq_in = '0;
        for (int i = 0; i < 16; i++)
            mem[i] = {14'h2A5, ADDR_W'(i)};
        for (int j = 0; j < 4; j++)
            h[j] = '{default: 0};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h0);
        chk(rd, 32'(CTRL_RST));
        chk(drive_strength_sel, 1'b1);
        apb(1'b0, 8'h08, 32'h0);
        chk({err, rd}, 33'h100000000);
        for (int i = 0; i < 9; i++)
        begin
            cfg = {i[2] ^ i[0], i == 8, i[2], i[1], i[0]};
            apb(1'b1, REG_CTRL, 32'(cfg));
            apb(1'b0, REG_CTRL, 32'h0);
            chk(rd, 32'(cfg));
            chk(drive_strength_sel, cfg[4]);
            for (int s = 0; s < 60; s++)
                step(s == 0 ? 2 : s < 5 ? 3 : int'($urandom_range(4)));
            repeat (4) step(0);
            apb(1'b0, REG_STATUS, 32'h0);
            chk(rd, 32'({cfg[3], beat,
                cfg[0] ? base ^ beat : base + beat}));
            $display("test with mode %h done", cfg);
        end
        complete_run();
    end

    initial
    begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        complete_run();
    end
endmodule
